// file: src/host_bus_pkg.sv
/*
  Shared constants and carrier types for the card-mode host bus unit.
  Assumes a single 100 MHz clock domain and 8-bit host data.
*/
package host_bus_pkg;
  localparam int          HOST_ADDR_W     = 15;
  localparam int          MEM_ADDR_W      = 17;
  localparam int          DATA_W          = 8;
  localparam logic [14:0] ATTR_CFG_OPTION = 15'h0800;
  localparam logic [14:0] ATTR_CFG_STATUS = 15'h0802;
  localparam logic [14:0] ATTR_CIS_LIMIT  = 15'h0800;
  localparam logic [1:0]  FLASH_TOP_BANK  = 2'h3;
  localparam logic        FLASH_TOP_HALF  = 1'h1;
  localparam logic [7:0]  CFG_OPTION_RST  = 8'h00;
  localparam logic [7:0]  CFG_STATUS_RST  = 8'h00;
  localparam logic [5:0]  CONF_INDEX_MASK = 6'h3f;
  localparam logic [4:0]  IO_BASE_MASK_16 = 5'h10;
  localparam logic [5:0]  IO_WIN_16       = 6'h10;
  localparam logic [5:0]  IO_WIN_40       = 6'h28;
  localparam logic [5:0]  IO_GCR          = 6'h00;
  localparam logic [5:0]  IO_BANK_SWITCH  = 6'h01;
  localparam logic [5:0]  IO_LMA_LO       = 6'h02;
  localparam logic [5:0]  IO_LMA_HI       = 6'h03;
  localparam logic [5:0]  IO_DATA_FIRST   = 6'h04;
  localparam logic [5:0]  IO_DATA_LAST    = 6'h07;
  localparam logic [5:0]  IO_XCVR_FIRST   = 6'h08;
  localparam logic [5:0]  IO_XCVR_LAST    = 6'h27;
  localparam logic [4:0]  XCVR_CTRL_11    = 5'h0b;
  localparam int          LOCK_BIT        = 4;
  localparam int          DEV_SEL_BIT     = 5;
  localparam int          BANK_HI_BIT     = 4;
  localparam int          BANK_LO_BIT     = 3;
  localparam int          EXTENDED_IO_WINDOW_BIT_BIT        = 2;
  localparam logic [7:0]  BANK_SWITCH_RST = 8'h00;
  localparam logic [7:0]  GCR_RST         = 8'h00;
  localparam logic [14:0] LMA_RST         = 15'h0000;
  localparam logic [14:0] LMA_STEP        = 15'h0001;
  localparam logic [7:0]  XCVR_RST        = 8'h00;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic        ce1_n;
    logic        oe_n;
    logic        we_n;
    logic        reg_n;
    logic        iord_n;
    logic        iowr_n;
  } host_bus_t;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic        flash_ce_n;
    logic        sram_ce_n;
    logic        rd_n;
    logic        wr_n;
  } mem_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CYCLE = 3'b010,
    ST_DONE  = 3'b100
  } io_state_t;
endpackage

// file: src/pc_card_host_bus_unit.sv
/*
  Card-mode host bus unit: decodes host memory, attribute and I/O cycles,
  steers common memory to external SRAM/Flash, holds the card config regs.
  Assumes host strobes are asynchronous and are synchronised here; the
  external memory answers within the host strobe time.
*/
`timescale 1ns/1ps
`default_nettype none

module pc_card_host_bus_unit (
  input  wire logic        CLK_IN,          // 100 MHz clock
  input  wire logic        RST_N_IN,        // async reset, active low
  input  wire logic        ISA_STRAP_IN,    // mode strap, 1 = card mode
  input  wire logic [14:0] HOST_ADDR_IN,    // host address
  input  wire logic [7:0]  HOST_DATA_IN,    // host write data
  input  wire logic        HOST_CE1_N_IN,   // card enable
  input  wire logic        HOST_OE_N_IN,    // memory output enable
  input  wire logic        HOST_WE_N_IN,    // memory write enable
  input  wire logic        HOST_REG_N_IN,   // attribute / io select
  input  wire logic        HOST_IORD_N_IN,  // io read
  input  wire logic        HOST_IOWR_N_IN,  // io write
  input  wire logic [5:0]  IO_BASE_IN,      // io window base, 8-byte units
  output logic      [7:0]  HOST_DATA_OUT,   // host read data
  output logic             HOST_DATA_OE_OUT,// host data drive enable
  output logic             HOST_INPACK_OUT, // io read acknowledged
  output logic      [16:0] MEM_ADDR_OUT,    // memory bus address
  output logic      [7:0]  MEM_DATA_OUT,    // memory bus write data
  output logic             MEM_DATA_OE_OUT, // memory data drive enable
  input  wire logic [7:0]  MEM_DATA_IN,     // memory bus read data
  output logic             FLASH_CE_N_OUT,  // flash chip enable
  output logic             SRAM_CE_N_OUT,   // sram chip enable
  output logic             MEM_RD_N_OUT,    // memory read strobe
  output logic             MEM_WR_N_OUT,    // memory write strobe
  input  wire logic        LOCK_PIN_IN,     // lock-detect / address pin in
  output logic             LOCK_PIN_OUT,    // lock-detect pin drive value
  output logic             LOCK_PIN_OE_OUT, // lock-detect pin drive enable
  output logic             SA15_OUT         // pin as address bit, isa mode
);

  host_bus_pkg::host_bus_t s1;
  host_bus_pkg::host_bus_t hb;
  logic                    lock_s1;
  logic                    lock_sync;
  logic                    strap_s1;
  logic                    card_mode;
  logic [7:0]              cfg_option;
  logic [7:0]              cfg_status;
  logic [7:0]              gcr;
  logic [7:0]              bank_switch_reg;
  logic [14:0]             local_mem_pointer;
  logic [7:0]              xcvr_regs [0:31];
  logic                    lock_output_enable;
  host_bus_pkg::io_state_t io_state;
  host_bus_pkg::io_state_t next_io_state;

  // two-flop synchronisers on all host pins
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      s1       <= '1;
      hb       <= '1;
      lock_s1  <= 1'b0;
      lock_sync<= 1'b0;
      strap_s1 <= 1'b0;
      card_mode<= 1'b0;
    end
    else
    begin
      s1       <= '{HOST_ADDR_IN, HOST_DATA_IN, HOST_CE1_N_IN, HOST_OE_N_IN,
                    HOST_WE_N_IN, HOST_REG_N_IN, HOST_IORD_N_IN,
                    HOST_IOWR_N_IN};
      hb       <= s1;
      lock_s1  <= LOCK_PIN_IN;
      lock_sync<= lock_s1;
      strap_s1 <= ISA_STRAP_IN;
      card_mode<= strap_s1;
    end
  end

  // decode
  logic        card_sel;
  logic        mem_cycle;
  logic        attr_cycle;
  logic        io_cycle;
  logic        io_enabled;
  logic [5:0]  io_off;
  logic [5:0]  io_size;
  logic        io_hit;
  logic        attr_cis;
  logic        attr_odd;
  logic        attr_opt;
  logic        attr_sts;

  assign card_sel   = card_mode && !hb.ce1_n;
  // memory response has no enable bit of its own
  assign mem_cycle  = card_sel && hb.reg_n
                      && (!hb.oe_n || !hb.we_n);
  assign attr_cycle = card_sel && !hb.reg_n && (!hb.oe_n || !hb.we_n);
  assign io_enabled = (cfg_option[5:0] & host_bus_pkg::CONF_INDEX_MASK)
                      != 6'h00;
  assign io_size    = bank_switch_reg[host_bus_pkg::EXTENDED_IO_WINDOW_BIT_BIT]
                      ? host_bus_pkg::IO_WIN_40
                      : host_bus_pkg::IO_WIN_16;
  assign io_off     = hb.addr[5:0] - {IO_BASE_IN[2:0], 3'h0};
  assign io_hit     = (hb.addr[14:6] == {6'h00, IO_BASE_IN[5:3]})
                      && (io_off < io_size);
  assign io_cycle   = card_sel && !hb.reg_n && io_enabled && io_hit
                      && (!hb.iord_n || !hb.iowr_n);
  assign attr_odd   = hb.addr[0];
  assign attr_cis   = hb.addr < host_bus_pkg::ATTR_CIS_LIMIT;
  assign attr_opt   = hb.addr == host_bus_pkg::ATTR_CFG_OPTION;
  assign attr_sts   = hb.addr == host_bus_pkg::ATTR_CFG_STATUS;

  logic        io_data_port;
  logic        io_xcvr;
  logic [4:0]  xcvr_idx;
  assign io_data_port = (io_off >= host_bus_pkg::IO_DATA_FIRST)
                        && (io_off <= host_bus_pkg::IO_DATA_LAST);
  assign io_xcvr      = (io_off >= host_bus_pkg::IO_XCVR_FIRST)
                        && (io_off <= host_bus_pkg::IO_XCVR_LAST)
                        && bank_switch_reg[host_bus_pkg::EXTENDED_IO_WINDOW_BIT_BIT];
  assign xcvr_idx     = 5'(io_off - host_bus_pkg::IO_XCVR_FIRST);

  // io cycle tracking: one action per host strobe
  always_comb
  begin
    next_io_state = io_state;
    case (io_state)
      host_bus_pkg::ST_IDLE:
        if (io_cycle)
          next_io_state = host_bus_pkg::ST_CYCLE;
      host_bus_pkg::ST_CYCLE:
        next_io_state = host_bus_pkg::ST_DONE;
      host_bus_pkg::ST_DONE:
        if (hb.iord_n && hb.iowr_n)
          next_io_state = host_bus_pkg::ST_IDLE;
      default:
        next_io_state = host_bus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      io_state <= host_bus_pkg::ST_IDLE;
    else
      io_state <= next_io_state;
  end

  logic io_act;
  logic io_wr_act;
  assign io_act    = io_state == host_bus_pkg::ST_CYCLE;
  assign io_wr_act = io_act && !hb.iowr_n;

  // host-only register set, never seen by the core
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      gcr             <= host_bus_pkg::GCR_RST;
      bank_switch_reg <= host_bus_pkg::BANK_SWITCH_RST;
    end
    else if (io_wr_act)
    begin
      if (io_off == host_bus_pkg::IO_GCR)
        gcr <= hb.wdata;
      if (io_off == host_bus_pkg::IO_BANK_SWITCH)
        bank_switch_reg <= hb.wdata;
    end
  end

  // pointer: loads from host, steps on every data port access
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      local_mem_pointer <= host_bus_pkg::LMA_RST;
    else if (io_wr_act && io_off == host_bus_pkg::IO_LMA_LO)
      local_mem_pointer[7:0] <= hb.wdata;
    else if (io_wr_act && io_off == host_bus_pkg::IO_LMA_HI)
      local_mem_pointer[14:8] <= hb.wdata[6:0];
    else if (io_act && io_data_port)
      local_mem_pointer <= local_mem_pointer
                           + host_bus_pkg::LMA_STEP;
  end

  // transceiver registers reachable from the host
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_xcvr
      always_ff @(posedge CLK_IN or negedge RST_N_IN)
      begin
        if (!RST_N_IN)
          xcvr_regs[gi] <= host_bus_pkg::XCVR_RST;
        else if (io_wr_act && io_xcvr && xcvr_idx == 5'(gi))
          xcvr_regs[gi] <= hb.wdata;
      end
    end
  endgenerate

  assign lock_output_enable = gcr[6];

  // lock pin direction and value
  always_comb
  begin
    LOCK_PIN_OE_OUT = card_mode && lock_output_enable;
    LOCK_PIN_OUT    = xcvr_regs[host_bus_pkg::XCVR_CTRL_11]
                      [host_bus_pkg::LOCK_BIT];
  end

  // in isa mode the pin is an address input
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      SA15_OUT <= 1'b0;
    else
      SA15_OUT <= !card_mode && lock_sync;
  end

  // card configuration registers
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      cfg_option <= host_bus_pkg::CFG_OPTION_RST;
      cfg_status <= host_bus_pkg::CFG_STATUS_RST;
    end
    else if (attr_cycle && !hb.we_n)
    begin
      if (attr_opt)
        cfg_option <= hb.wdata;
      if (attr_sts)
        cfg_status <= hb.wdata;
    end
  end

  // memory bus steering
  logic mem_fwd;
  logic attr_fwd;
  logic io_fwd;
  assign mem_fwd  = mem_cycle;
  assign attr_fwd = attr_cycle && attr_cis && !attr_odd;
  assign io_fwd   = (io_state != host_bus_pkg::ST_IDLE) && io_data_port;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      MEM_ADDR_OUT    <= '0;
      MEM_DATA_OUT    <= '0;
      MEM_DATA_OE_OUT <= 1'b0;
      FLASH_CE_N_OUT  <= 1'b1;
      SRAM_CE_N_OUT   <= 1'b1;
      MEM_RD_N_OUT    <= 1'b1;
      MEM_WR_N_OUT    <= 1'b1;
    end
    else
    begin
      MEM_DATA_OUT    <= hb.wdata;
      FLASH_CE_N_OUT  <= 1'b1;
      SRAM_CE_N_OUT   <= 1'b1;
      MEM_RD_N_OUT    <= 1'b1;
      MEM_WR_N_OUT    <= 1'b1;
      MEM_DATA_OE_OUT <= 1'b0;
      if (mem_fwd)
      begin
        MEM_ADDR_OUT <= {bank_switch_reg[host_bus_pkg::BANK_HI_BIT],
                         bank_switch_reg[host_bus_pkg::BANK_LO_BIT],
                         hb.addr};
        FLASH_CE_N_OUT  <= !bank_switch_reg[host_bus_pkg::DEV_SEL_BIT];
        SRAM_CE_N_OUT   <= bank_switch_reg[host_bus_pkg::DEV_SEL_BIT];
        MEM_RD_N_OUT    <= hb.oe_n;
        MEM_WR_N_OUT    <= hb.we_n;
        MEM_DATA_OE_OUT <= !hb.we_n;
      end
      else if (attr_fwd)
      begin
        // flash top kilobyte, read only
        MEM_ADDR_OUT   <= {host_bus_pkg::FLASH_TOP_BANK,
                           host_bus_pkg::FLASH_TOP_HALF,
                           4'hf, hb.addr[10:1]};
        FLASH_CE_N_OUT <= 1'b0;
        MEM_RD_N_OUT   <= hb.oe_n;
      end
      else if (io_fwd)
      begin
        if (io_act)
          MEM_ADDR_OUT <= {bank_switch_reg[host_bus_pkg::BANK_HI_BIT],
                           bank_switch_reg[host_bus_pkg::BANK_LO_BIT],
                           local_mem_pointer};
        FLASH_CE_N_OUT  <= !bank_switch_reg[host_bus_pkg::DEV_SEL_BIT];
        SRAM_CE_N_OUT   <= bank_switch_reg[host_bus_pkg::DEV_SEL_BIT];
        MEM_RD_N_OUT    <= hb.iord_n;
        MEM_WR_N_OUT    <= hb.iowr_n;
        MEM_DATA_OE_OUT <= !hb.iowr_n;
      end
    end
  end

  // host read data
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (attr_cycle)
    begin
      if (attr_opt)
        next_rdata = cfg_option;
      else if (attr_sts)
        next_rdata = cfg_status;
      else if (attr_cis && !attr_odd)
        next_rdata = MEM_DATA_IN;
      else
        next_rdata = 8'h00;
    end
    else if (mem_cycle || (io_cycle && io_data_port))
      next_rdata = MEM_DATA_IN;
    else if (io_cycle)
    begin
      if (io_off == host_bus_pkg::IO_GCR)
        next_rdata = gcr;
      else if (io_off == host_bus_pkg::IO_BANK_SWITCH)
        next_rdata = bank_switch_reg;
      else if (io_off == host_bus_pkg::IO_LMA_LO)
        next_rdata = local_mem_pointer[7:0];
      else if (io_off == host_bus_pkg::IO_LMA_HI)
        next_rdata = {1'b0, local_mem_pointer[14:8]};
      else if (io_xcvr && xcvr_idx == host_bus_pkg::XCVR_CTRL_11)
      begin
        next_rdata = xcvr_regs[xcvr_idx];
        next_rdata[host_bus_pkg::LOCK_BIT] = lock_sync;
      end
      else if (io_xcvr)
        next_rdata = xcvr_regs[xcvr_idx];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      HOST_DATA_OUT    <= 8'h00;
      HOST_DATA_OE_OUT <= 1'b0;
      HOST_INPACK_OUT  <= 1'b0;
    end
    else
    begin
      HOST_DATA_OUT    <= next_rdata;
      HOST_DATA_OE_OUT <= ((mem_cycle || attr_cycle) && !hb.oe_n)
                          || (io_cycle && !hb.iord_n);
      HOST_INPACK_OUT  <= io_cycle && !hb.iord_n;
    end
  end

endmodule
`default_nettype wire

// file: verification/mem_partner.sv
/*
  Behavioural flash and sram on the memory bus of the host bus unit.
  Assumes registered strobes from the unit; reads answer in the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input  wire logic        clk_in,        // clock
  input  wire logic [16:0] addr_in,       // memory address
  input  wire logic [7:0]  wdata_in,      // write data
  input  wire logic        flash_ce_n_in, // flash select
  input  wire logic        sram_ce_n_in,  // sram select
  input  wire logic        rd_n_in,       // read strobe
  input  wire logic        wr_n_in,       // write strobe
  output logic      [7:0]  rdata_out      // read data
);
  logic [7:0] flash [0:131071];
  logic [7:0] sram  [0:131071];
  logic [7:0] last = 8'h00;
  // first card info byte sits at attribute zero; top 8 bytes left unused
  // config tuple names the register base 2K in attribute bytes 4 and 6
  initial
  begin
    flash[17'h1_fc00] = 8'h01;
    flash[17'h1_fc02] = 8'h00;
    flash[17'h1_fc03] = 8'h08;
  end
  always @(posedge clk_in)
  begin
    if (!wr_n_in && !sram_ce_n_in)
      sram[addr_in] <= wdata_in;
    if (!wr_n_in && !flash_ce_n_in)
      flash[addr_in] <= wdata_in;
    last <= rdata_out;
  end
  // released bus toggles so stale data never looks valid
  always_comb
    if (!rd_n_in && !sram_ce_n_in)
      rdata_out = sram[addr_in];
    else if (!rd_n_in && !flash_ce_n_in)
      rdata_out = flash[addr_in];
    else
      rdata_out = ~last;
endmodule
`default_nettype wire

// file: verification/host_bus_checker_assertions.sv
/*
  Port checker for the card-mode host bus unit, bound to its top module.
  Assumes host pins pass two sync flops plus one output register.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_checker (
  input wire logic        CLK_IN,          // clock
  input wire logic        RST_N_IN,        // reset, active low
  input wire logic        ISA_STRAP_IN,    // mode strap
  input wire logic [14:0] HOST_ADDR_IN,    // host address
  input wire logic        HOST_CE1_N_IN,   // card enable
  input wire logic        HOST_OE_N_IN,    // output enable
  input wire logic        HOST_WE_N_IN,    // write enable
  input wire logic        HOST_REG_N_IN,   // attribute select
  input wire logic        HOST_IORD_N_IN,  // io read
  input wire logic        HOST_IOWR_N_IN,  // io write
  input wire logic        HOST_INPACK_OUT, // io acknowledge
  input wire logic [16:0] MEM_ADDR_OUT,    // memory address
  input wire logic        MEM_DATA_OE_OUT, // memory data enable
  input wire logic        FLASH_CE_N_OUT,  // flash enable
  input wire logic        SRAM_CE_N_OUT,   // sram enable
  input wire logic        MEM_RD_N_OUT,    // memory read
  input wire logic        MEM_WR_N_OUT,    // memory write
  input wire logic        LOCK_PIN_OE_OUT  // lock pin enable
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic mem_cyc;
  logic cmn;
  logic attr;
  logic quiet;
  assign mem_cyc = ISA_STRAP_IN && !HOST_CE1_N_IN
                   && (!HOST_OE_N_IN || !HOST_WE_N_IN);
  assign cmn = mem_cyc && HOST_REG_N_IN;
  assign attr = mem_cyc && !HOST_REG_N_IN;
  assign quiet = HOST_CE1_N_IN && HOST_IORD_N_IN && HOST_IOWR_N_IN;
  chip_exclusive_a: assert property (FLASH_CE_N_OUT || SRAM_CE_N_OUT)
    else $error("both chip enables low");
  strobe_select_a: assert property (!MEM_RD_N_OUT || !MEM_WR_N_OUT
    |-> !(FLASH_CE_N_OUT && SRAM_CE_N_OUT)) else $error("strobe, no chip");
  write_drive_a: assert property (!MEM_WR_N_OUT |-> MEM_DATA_OE_OUT)
    else $error("memory write without data drive");
  common_addr_a: assert property (cmn[*4] |->
    MEM_ADDR_OUT[14:0] == $past(HOST_ADDR_IN, 3)) else $error("bad addr");
  attr_even_a: assert property ((attr && !HOST_ADDR_IN[0]
    && HOST_ADDR_IN < 15'h0800)[*4] |-> !FLASH_CE_N_OUT && MEM_ADDR_OUT ==
    {7'h7f, $past(HOST_ADDR_IN[10:1], 3)}) else $error("bad cis map");
  attr_none_a: assert property ((attr && (HOST_ADDR_IN[0]
    || HOST_ADDR_IN >= 15'h0800))[*4] |-> FLASH_CE_N_OUT && SRAM_CE_N_OUT)
    else $error("memory hit on odd or config attribute");
  isa_silent_a: assert property ((!ISA_STRAP_IN)[*4] |-> FLASH_CE_N_OUT
    && SRAM_CE_N_OUT && !HOST_INPACK_OUT && !LOCK_PIN_OE_OUT)
    else $error("answer in isa mode");
  idle_quiet_a: assert property (quiet[*4] |-> MEM_RD_N_OUT
    && MEM_WR_N_OUT) else $error("memory strobe with host idle");
  inpack_cause_a: assert property (HOST_INPACK_OUT |->
    !$past(HOST_IORD_N_IN, 3) || !$past(HOST_IORD_N_IN, 4))
    else $error("acknowledge without io read");
endmodule
bind pc_card_host_bus_unit host_bus_checker chk (.CLK_IN, .RST_N_IN,
  .ISA_STRAP_IN, .HOST_ADDR_IN, .HOST_CE1_N_IN, .HOST_OE_N_IN, .HOST_WE_N_IN,
  .HOST_REG_N_IN, .HOST_IORD_N_IN, .HOST_IOWR_N_IN, .HOST_INPACK_OUT,
  .MEM_ADDR_OUT, .MEM_DATA_OE_OUT, .FLASH_CE_N_OUT, .SRAM_CE_N_OUT,
  .MEM_RD_N_OUT, .MEM_WR_N_OUT, .LOCK_PIN_OE_OUT);
`default_nettype wire

// file: verification/pc_card_host_bus_unit_bench.sv
/*
  Self-checking bench for the card-mode host bus unit with memory model.
  Assumes io window base 0 and host cycles held six clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module pc_card_host_bus_unit_bench;
  localparam logic [5:0] CRD = 6'b001111;
  localparam logic [5:0] CWR = 6'b010111;
  localparam logic [5:0] ARD = 6'b001011;
  localparam logic [5:0] AWR = 6'b010011;
  localparam logic [5:0] IRD = 6'b011001;
  localparam logic [5:0] IWR = 6'b011010;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b1;
  logic lock_drv = 1'b0;
  host_bus_pkg::host_bus_t hb = {15'h0000, 8'h00, 6'b111111};
  logic [7:0] hd, md, mdi, rd_v, bsw, dv;
  logic [16:0] ma, ma_v;
  logic hoe, inp, mdoe, fce, sram_chip_enable, mrd, mwr, lk, lkoe, sa15, lock_w, ack_v;
  logic oe_v;
  logic [1:0] ce_v;
  logic [14:0] a;
  logic [7:0] mdl [int];
  int num_errors = 0;
  int total_checks = 0;
  int ad;
  always #5 clk = ~clk;
  assign lock_w = lkoe ? lk : lock_drv;
  pc_card_host_bus_unit DUT (.CLK_IN(clk), .RST_N_IN(rst_n),
    .ISA_STRAP_IN(strap), .HOST_ADDR_IN(hb.addr), .HOST_DATA_IN(hb.wdata),
    .HOST_CE1_N_IN(hb.ce1_n), .HOST_OE_N_IN(hb.oe_n), .HOST_WE_N_IN(hb.we_n),
    .HOST_REG_N_IN(hb.reg_n), .HOST_IORD_N_IN(hb.iord_n),
    .HOST_IOWR_N_IN(hb.iowr_n), .IO_BASE_IN(6'h00), .HOST_DATA_OUT(hd),
    .HOST_DATA_OE_OUT(hoe), .HOST_INPACK_OUT(inp), .MEM_ADDR_OUT(ma),
    .MEM_DATA_OUT(md), .MEM_DATA_OE_OUT(mdoe), .MEM_DATA_IN(mdi),
    .FLASH_CE_N_OUT(fce), .SRAM_CE_N_OUT(sram_chip_enable), .MEM_RD_N_OUT(mrd),
    .MEM_WR_N_OUT(mwr), .LOCK_PIN_IN(lock_w), .LOCK_PIN_OUT(lk),
    .LOCK_PIN_OE_OUT(lkoe), .SA15_OUT(sa15));
  mem_partner mem (.clk_in(clk), .addr_in(ma), .wdata_in(md),
    .flash_ce_n_in(fce), .sram_ce_n_in(sram_chip_enable), .rd_n_in(mrd), .wr_n_in(mwr),
    .rdata_out(mdi));
  function automatic int key(input logic [2:0] db, input int adr);
    return (int'(db) << 15) + (adr & 32'h7fff);
  endfunction
  // one host cycle: hold strobes six clocks, sample, release four clocks
  task automatic cyc(input logic [14:0] adr, input logic [7:0] d,
                     input logic [5:0] s);
    @(posedge clk);
    #1 hb = {adr, d, s};
    repeat (6) @(posedge clk);
    #1 rd_v = hd;
    ack_v = inp;
    oe_v = hoe;
    ma_v = ma;
    ce_v = {fce, sram_chip_enable};
    hb = {15'h0000, 8'h00, 6'b111111};
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done;
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #500_000;
    num_errors++;
    test_done;
  end
  initial
  begin
    void'($urandom(85979));
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    cyc(15'h0123, 8'ha5, CWR);
    `CHK(oe_v, 1'b0)
    cyc(15'h0123, 8'h00, CRD);
    `CHK(rd_v, 8'ha5)
    `CHK(oe_v, 1'b1)
    cyc(15'h0001, 8'h00, IRD);
    `CHK(ack_v, 1'b0)
    cyc(15'h0800, 8'h00, ARD);
    `CHK(rd_v, 8'h00)
    cyc(15'h0800, 8'h01, AWR);
    cyc(15'h0802, 8'h5a, AWR);
    cyc(15'h0800, 8'h00, ARD);
    `CHK(rd_v, 8'h01)
    cyc(15'h0802, 8'h00, ARD);
    `CHK(rd_v, 8'h5a)
    for (int i = 0; i < 8; i++)
    begin
      bsw = {2'b00, i[0], 2'($urandom), 3'b000};
      cyc(15'h0001, bsw, IWR);
      a = 15'($urandom) & 15'h7ff0;
      dv = 8'($urandom);
      cyc(a, dv, CWR);
      mdl[key(bsw[5:3], a)] = dv;
      `CHK(ma_v, {bsw[4:3], a})
      `CHK(ce_v, bsw[5] ? 2'b01 : 2'b10)
      cyc(a, 8'h00, CRD);
      `CHK(rd_v, mdl[key(bsw[5:3], a)])
    end
    cyc(15'h0002, a[7:0], IWR);
    cyc(15'h0003, {1'b0, a[14:8]}, IWR);
    for (int p = 4; p < 8; p++)
    begin
      dv = 8'($urandom);
      cyc(15'(p), dv, IWR);
      mdl[key(bsw[5:3], a + p - 4)] = dv;
    end
    cyc(15'h0002, a[7:0], IWR);
    for (int p = 7; p > 3; p--)
    begin
      cyc(15'(p), 8'h00, IRD);
      `CHK(ack_v, 1'b1)
      `CHK(rd_v, mdl[key(bsw[5:3], a + 7 - p)])
    end
    cyc(15'h0001, 8'h38, IWR);
    cyc(15'h0000, 8'h00, ARD);
    `CHK(rd_v, 8'h01)
    cyc(15'h0004, 8'h00, ARD);
    `CHK(rd_v, 8'h00)
    cyc(15'h0006, 8'h00, ARD);
    `CHK(rd_v, 8'h08)
    for (int k = 0; k < 4; k++)
    begin
      ad = 2 + 2 * ($urandom % 1015);
      dv = 8'($urandom);
      cyc(15'h7c00 + 15'(ad / 2), dv, CWR);
      cyc(15'(ad), 8'h00, ARD);
      `CHK(rd_v, dv)
      cyc(15'(ad + 1), 8'h00, ARD);
      `CHK(rd_v, 8'h00)
    end
    cyc(15'h0013, 8'h00, IRD);
    `CHK(ack_v, 1'b0)
    cyc(15'h0001, 8'h1c, IWR);
    for (int v = 0; v < 2; v++)
    begin
      #1 lock_drv = v[0];
      cyc(15'h0013, 8'h00, IRD);
      `CHK(ack_v, 1'b1)
      `CHK(rd_v, {3'b000, v[0], 4'h0})
    end
    #1 lock_drv = 1'b0;
    cyc(15'h0013, 8'h10, IWR);
    cyc(15'h0000, 8'h40, IWR);
    `CHK({lkoe, lk}, 2'b11)
    cyc(15'h0013, 8'h00, IRD);
    `CHK(rd_v, 8'h10)
    cyc(15'h0000, 8'h00, IWR);
    `CHK(lkoe, 1'b0)
    #1 strap = 1'b0;
    lock_drv = 1'b1;
    repeat (4) @(posedge clk);
    cyc(15'h0123, 8'h00, CRD);
    `CHK(ce_v, 2'b11)
    `CHK({lkoe, sa15}, 2'b01)
    test_done;
  end
endmodule
`default_nettype wire
